// *** pkg/pmic_cfg_pkg.sv ***
// Package with register map, field positions and state codes of the configuration bank
//
// Summary of operation
// - Boost active bit 1 adds a discharge when boost enable is written 00.
// - Start-in-off 1 keeps off after power-on reset; 0 starts the sequence.
// - Global passive discharge 1 enables passive loads in off mode, 0 disables.
// - Read-only converter select picks LDO-input (0) or converter-input (1) thresholds.
// - LDO select picks converter-input (1) or LDO-input (0) thresholds for the LDO.
`default_nettype none
package pmic_cfg_pkg;
  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_DISCHARGE = 8'h1C;
  localparam logic [7:0] IDX_HANDSHAKE = 8'h1D;
  localparam logic [7:0] IDX_UV_SOURCE = 8'h1E;
  localparam logic [7:0] IDX_ENABLES = 8'h20;
  localparam logic [7:0] ADDR_DISCHARGE = {IDX_DISCHARGE[5:0], 2'h0};
  localparam logic [7:0] ADDR_HANDSHAKE = {IDX_HANDSHAKE[5:0], 2'h0};
  localparam logic [7:0] ADDR_UV_SOURCE = {IDX_UV_SOURCE[5:0], 2'h0};
  localparam logic [7:0] ADDR_ENABLES = {IDX_ENABLES[5:0], 2'h0};
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_BOOST_HYS_OFF = 7;
  localparam int BIT_BOOST_PAS = 6;
  localparam int BIT_BOOST_ACT = 5;
  localparam int BIT_BUCK_PAS = 2;
  localparam int BIT_BUCK_ACT = 1;
  localparam int BIT_BUCK_FET_SCALE = 0;
  localparam int BIT_START_OFF = 7;
  localparam int BIT_GLOBAL_PAS = 6;
  localparam int BIT_CONV_UV_SEL = 1;
  localparam int BIT_LDO_UV_SEL = 0;
  localparam int BOOST_EN_LSB = 0;
  localparam int BUCK_EN_LSB = 2;
  localparam logic [1:0] EN_FIELD_OFF = 2'h0;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] DISCHARGE_RESET = 8'h00;
  localparam logic LDO_UV_SEL_RESET = 1'h0;
  localparam logic [1:0] EN_FIELD_RESET = 2'h0;
  // ----------------------------------------------------------------
  // Power mode states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_POR = 4'h1,
    ST_OFF = 4'h2,
    ST_SEQ = 4'h4,
    ST_ON = 4'h8
  } power_state_t;
endpackage : pmic_cfg_pkg
`default_nettype wire

// *** hw/pin_sync3.sv ***
// Three-stage synchroniser for a pin; output follows once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_next;

  // Only the second stage reads the first one
  assign level_next = (s2_reg == s3_reg) ? s3_reg : level;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 1'h0;
      s2_reg <= 1'h0;
      s3_reg <= 1'h0;
      level <= 1'h0;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level <= level_next;
    end
  end
endmodule : pin_sync3
`default_nettype wire

// *** hw/output_discharge.sv ***
// One discharge path: fires on mode entry, and on an enable-off write when policy allows
`timescale 1ns/1ps
`default_nettype none
module output_discharge (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic policy_bit,
  input wire logic enable_off_write,
  input wire logic mode_entry,
  output logic discharge
);
  logic discharge_next;

  assign discharge_next = mode_entry | (policy_bit & enable_off_write);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      discharge <= 1'h0;
    end else begin
      discharge <= discharge_next;
    end
  end

  entry_only_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!policy_bit && !mode_entry) |=> !discharge)
    else $error("discharge fired without entry while policy bit is 0");
endmodule : output_discharge
`default_nettype wire

// *** hw/pmic_discharge_uvlo_config.sv ***
// Discharge, start-up and undervoltage-source configuration bank behind an APB slave
`timescale 1ns/1ps
`default_nettype none
module pmic_discharge_uvlo_config #(
  parameter logic CONV_UV_SELECT = 1'h1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic por_done_pin,
  input wire logic start_in_off_pin,
  input wire logic global_passive_pin,
  input wire logic enter_off_req,
  input wire logic hard_reset_req,
  input wire logic wake_req,
  output logic boost_passive_discharge,
  output logic boost_active_discharge,
  output logic buck_passive_discharge,
  output logic buck_active_discharge,
  output logic passive_loads_enable,
  output logic power_sequence_start,
  output logic in_off_mode,
  output logic boost_hysteresis_off,
  output logic buck_fet_scaling,
  output logic [1:0] boost_enable_field,
  output logic [1:0] buck_enable_field,
  output logic converter_uv_use_converter_input,
  output logic ldo_uv_use_converter_input
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] discharge_reg;
  logic start_in_off_reg;
  logic global_passive_reg;
  logic conv_uv_sel_reg;
  logic ldo_uv_sel_reg;
  logic [1:0] boost_en_reg;
  logic [1:0] buck_en_reg;
  logic [31:0] prdata_reg;
  logic passive_reg;
  pmic_cfg_pkg::power_state_t state_reg;
  pmic_cfg_pkg::power_state_t state_next;

  logic por_done_sync;
  logic start_in_off_sync;
  logic global_passive_sync;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  pin_sync3 u_sync_por (
    .pclk(pclk),
    .presetn(presetn),
    .pin(por_done_pin),
    .level(por_done_sync)
  );
  pin_sync3 u_sync_start (
    .pclk(pclk),
    .presetn(presetn),
    .pin(start_in_off_pin),
    .level(start_in_off_sync)
  );
  pin_sync3 u_sync_glb (
    .pclk(pclk),
    .presetn(presetn),
    .pin(global_passive_pin),
    .level(global_passive_sync)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire hit_discharge = (paddr == pmic_cfg_pkg::ADDR_DISCHARGE);
  wire hit_handshake = (paddr == pmic_cfg_pkg::ADDR_HANDSHAKE);
  wire hit_uv = (paddr == pmic_cfg_pkg::ADDR_UV_SOURCE);
  wire hit_enables = (paddr == pmic_cfg_pkg::ADDR_ENABLES);
  wire addr_hit = hit_discharge | hit_handshake | hit_uv | hit_enables;
  wire access = psel & penable;
  wire setup_rd = psel & ~penable & ~pwrite;
  wire wr_ok = access & pwrite & addr_hit;
  wire wr_discharge = wr_ok & hit_discharge;
  wire wr_uv = wr_ok & hit_uv;
  wire wr_enables = wr_ok & hit_enables;

  // Unused positions are masked out of the stored value
  wire [7:0] discharge_mask = 8'hE7;
  wire [7:0] discharge_wdata = pwdata[7:0] & discharge_mask;

  wire [1:0] boost_en_wdata = pwdata[pmic_cfg_pkg::BOOST_EN_LSB +: 2];
  wire [1:0] buck_en_wdata = pwdata[pmic_cfg_pkg::BUCK_EN_LSB +: 2];
  wire boost_off_write = wr_enables & (boost_en_wdata == pmic_cfg_pkg::EN_FIELD_OFF);
  wire buck_off_write = wr_enables & (buck_en_wdata == pmic_cfg_pkg::EN_FIELD_OFF);

  // Read mux, zero everywhere outside the defined bits
  wire [7:0] handshake_rd = {start_in_off_reg, global_passive_reg, 6'h00};
  wire [7:0] uv_rd = {6'h00, conv_uv_sel_reg, ldo_uv_sel_reg};
  wire [7:0] enables_rd = {4'h0, buck_en_reg, boost_en_reg};
  wire [7:0] rd_byte = hit_discharge ? discharge_reg :
                       hit_handshake ? handshake_rd :
                       hit_uv ? uv_rd :
                       hit_enables ? enables_rd : 8'h00;

  // Zero wait state: read data is captured in the setup cycle
  assign pready = 1'h1;
  assign pslverr = access & ~addr_hit;
  assign prdata = prdata_reg;

  // ----------------------------------------------------------------
  // Power mode sequencing
  // ----------------------------------------------------------------
  wire st_por = (state_reg == pmic_cfg_pkg::ST_POR);
  wire st_off = (state_reg == pmic_cfg_pkg::ST_OFF);
  wire st_on = (state_reg == pmic_cfg_pkg::ST_ON);
  wire next_off = (state_next == pmic_cfg_pkg::ST_OFF);
  // Straps track the pins until power-on reset completes, then freeze
  wire start_bit_next = st_por ? start_in_off_sync : start_in_off_reg;
  wire glb_bit_next = st_por ? global_passive_sync : global_passive_reg;
  wire hard_reset_entry = st_on & hard_reset_req & ~enter_off_req;
  wire mode_entry = (next_off & ~st_off) | hard_reset_entry;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      pmic_cfg_pkg::ST_POR: begin
        if (por_done_sync) begin
          state_next = start_bit_next ? pmic_cfg_pkg::ST_OFF : pmic_cfg_pkg::ST_SEQ;
        end
      end
      pmic_cfg_pkg::ST_OFF: begin
        if (wake_req) begin
          state_next = pmic_cfg_pkg::ST_SEQ;
        end
      end
      pmic_cfg_pkg::ST_SEQ: begin
        state_next = pmic_cfg_pkg::ST_ON;
      end
      pmic_cfg_pkg::ST_ON: begin
        if (enter_off_req) begin
          state_next = pmic_cfg_pkg::ST_OFF;
        end else if (hard_reset_req) begin
          state_next = pmic_cfg_pkg::ST_SEQ;
        end
      end
      default: begin
        state_next = pmic_cfg_pkg::ST_POR;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= pmic_cfg_pkg::ST_POR;
      start_in_off_reg <= 1'h0;
      global_passive_reg <= 1'h0;
      passive_reg <= 1'h0;
    end else begin
      state_reg <= state_next;
      start_in_off_reg <= start_bit_next;
      global_passive_reg <= glb_bit_next;
      passive_reg <= next_off & glb_bit_next;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      discharge_reg <= pmic_cfg_pkg::DISCHARGE_RESET;
      ldo_uv_sel_reg <= pmic_cfg_pkg::LDO_UV_SEL_RESET;
      conv_uv_sel_reg <= 1'h0;
      boost_en_reg <= pmic_cfg_pkg::EN_FIELD_RESET;
      buck_en_reg <= pmic_cfg_pkg::EN_FIELD_RESET;
      prdata_reg <= 32'h0000_0000;
    end else begin
      // Read-only select is loaded from the build-time choice after reset
      conv_uv_sel_reg <= CONV_UV_SELECT;
      if (wr_discharge) begin
        discharge_reg <= discharge_wdata;
      end
      if (wr_uv) begin
        ldo_uv_sel_reg <= pwdata[pmic_cfg_pkg::BIT_LDO_UV_SEL];
      end
      if (wr_enables) begin
        boost_en_reg <= boost_en_wdata;
        buck_en_reg <= buck_en_wdata;
      end
      if (setup_rd) begin
        prdata_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ----------------------------------------------------------------
  // Discharge paths
  // ----------------------------------------------------------------
  // A write of 00 fires even if the field already was 00; a repeated
  // off-write is a cheap way for software to force another discharge.
  output_discharge u_boost_pas (
    .pclk(pclk),
    .presetn(presetn),
    .policy_bit(discharge_reg[pmic_cfg_pkg::BIT_BOOST_PAS]),
    .enable_off_write(boost_off_write),
    .mode_entry(mode_entry),
    .discharge(boost_passive_discharge)
  );
  output_discharge u_boost_act (
    .pclk(pclk),
    .presetn(presetn),
    .policy_bit(discharge_reg[pmic_cfg_pkg::BIT_BOOST_ACT]),
    .enable_off_write(boost_off_write),
    .mode_entry(mode_entry),
    .discharge(boost_active_discharge)
  );
  output_discharge u_buck_pas (
    .pclk(pclk),
    .presetn(presetn),
    .policy_bit(discharge_reg[pmic_cfg_pkg::BIT_BUCK_PAS]),
    .enable_off_write(buck_off_write),
    .mode_entry(mode_entry),
    .discharge(buck_passive_discharge)
  );
  output_discharge u_buck_act (
    .pclk(pclk),
    .presetn(presetn),
    .policy_bit(discharge_reg[pmic_cfg_pkg::BIT_BUCK_ACT]),
    .enable_off_write(buck_off_write),
    .mode_entry(mode_entry),
    .discharge(buck_active_discharge)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign passive_loads_enable = passive_reg;
  assign power_sequence_start = (state_reg == pmic_cfg_pkg::ST_SEQ);
  assign in_off_mode = st_off;
  assign boost_hysteresis_off = discharge_reg[pmic_cfg_pkg::BIT_BOOST_HYS_OFF];
  assign buck_fet_scaling = discharge_reg[pmic_cfg_pkg::BIT_BUCK_FET_SCALE];
  assign boost_enable_field = boost_en_reg;
  assign buck_enable_field = buck_en_reg;
  assign converter_uv_use_converter_input = conv_uv_sel_reg;
  assign ldo_uv_use_converter_input = ldo_uv_sel_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_boost_off_write;
    wr_enables && (pwdata[pmic_cfg_pkg::BOOST_EN_LSB +: 2] == pmic_cfg_pkg::EN_FIELD_OFF) &&
      discharge_reg[pmic_cfg_pkg::BIT_BOOST_ACT];
  endsequence

  sequence s_buck_off_write;
    wr_enables && (pwdata[pmic_cfg_pkg::BUCK_EN_LSB +: 2] == pmic_cfg_pkg::EN_FIELD_OFF) &&
      discharge_reg[pmic_cfg_pkg::BIT_BUCK_ACT];
  endsequence

  boost_off_dsc_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_boost_off_write |=> boost_active_discharge)
    else $error("boost active discharge missing after enable-off write");

  buck_off_dsc_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_buck_off_write |=> buck_active_discharge)
    else $error("buck active discharge missing after enable-off write");

  entry_dsc_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_on && (enter_off_req || hard_reset_req)) |=>
      (boost_passive_discharge && boost_active_discharge &&
       buck_passive_discharge && buck_active_discharge))
    else $error("discharge missing on entry to off or hard-reset mode");

  start_off_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_por && por_done_sync) |=>
      (start_in_off_reg ? in_off_mode : power_sequence_start) ##1 (st_on || in_off_mode))
    else $error("wrong start-up mode after power-on reset");

  passive_off_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_off && !global_passive_reg) [*2] |-> !passive_loads_enable)
    else $error("passive loads on in off mode while disabled");

  passive_on_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_off && global_passive_reg) [*2] |-> passive_loads_enable)
    else $error("passive loads off in off mode while enabled");

  // The select loads one edge after release, so the first edge is skipped
  conv_uv_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> (converter_uv_use_converter_input == CONV_UV_SELECT))
    else $error("read-only converter select differs from its fixed value");

  ldo_uv_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_uv |=> (ldo_uv_use_converter_input == $past(pwdata[pmic_cfg_pkg::BIT_LDO_UV_SEL])) ##1
      (ldo_uv_use_converter_input == $past(pwdata[pmic_cfg_pkg::BIT_LDO_UV_SEL], 2)) || wr_uv)
    else $error("LDO select does not follow the written value");

  reserved_rd_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_rd && hit_uv) |=> (prdata[31:2] == 30'h0000_0000))
    else $error("unused bits of undervoltage register read non-zero");
endmodule : pmic_discharge_uvlo_config
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the discharge, start-up and undervoltage-source bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic por_done_pin = 1'b0;
  logic start_in_off_pin = 1'b0;
  logic global_passive_pin = 1'b0;
  logic enter_off_req = 1'b0;
  logic hard_reset_req = 1'b0;
  logic wake_req = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, boost_passive_discharge, boost_active_discharge;
  logic buck_passive_discharge, buck_active_discharge, passive_loads_enable;
  logic power_sequence_start, in_off_mode, boost_hysteresis_off, buck_fet_scaling;
  logic converter_uv_use_converter_input, ldo_uv_use_converter_input;
  logic [1:0] boost_enable_field, buck_enable_field;
  int failures = 0;
  int checks = 0;
  int cnt [4];
  int seq_cnt = 0;

  pmic_discharge_uvlo_config u_pmic_discharge_uvlo_config (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .por_done_pin(por_done_pin),
    .start_in_off_pin(start_in_off_pin), .global_passive_pin(global_passive_pin),
    .enter_off_req(enter_off_req), .hard_reset_req(hard_reset_req), .wake_req(wake_req),
    .boost_passive_discharge(boost_passive_discharge),
    .boost_active_discharge(boost_active_discharge),
    .buck_passive_discharge(buck_passive_discharge),
    .buck_active_discharge(buck_active_discharge),
    .passive_loads_enable(passive_loads_enable),
    .power_sequence_start(power_sequence_start), .in_off_mode(in_off_mode),
    .boost_hysteresis_off(boost_hysteresis_off), .buck_fet_scaling(buck_fet_scaling),
    .boost_enable_field(boost_enable_field), .buck_enable_field(buck_enable_field),
    .converter_uv_use_converter_input(converter_uv_use_converter_input),
    .ldo_uv_use_converter_input(ldo_uv_use_converter_input));

  always #4 pclk = ~pclk;

  // --------------------------------------------------------------
  // Pulse counters; index 3 boost passive down to 0 buck active
  // --------------------------------------------------------------
  always @(posedge pclk) begin
    if (boost_passive_discharge === 1'b1) cnt[3]++;
    if (boost_active_discharge === 1'b1) cnt[2]++;
    if (buck_passive_discharge === 1'b1) cnt[1]++;
    if (buck_active_discharge === 1'b1) cnt[0]++;
    if (power_sequence_start === 1'b1) seq_cnt++;
  end

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task results;
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for pready at an edge; only the watchdog ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    check("pready", {31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h00000000, rd, err);
    check(name, rd, exp);
    check("pslverr", {31'h0, err}, 32'h0);
  endtask : rd_chk

  task clear_cnt;
    for (int i = 0; i < 4; i++) cnt[i] = 0;
  endtask : clear_cnt

  task req(input int k);
    @(posedge pclk);
    enter_off_req <= (k == 0);
    hard_reset_req <= (k == 1);
    wake_req <= (k == 2);
    @(posedge pclk);
    enter_off_req <= 1'b0;
    hard_reset_req <= 1'b0;
    wake_req <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : req

  task do_reset(input logic sio, input logic gp);
    @(posedge pclk);
    presetn <= 1'b0;
    por_done_pin <= 1'b0;
    start_in_off_pin <= sio;
    global_passive_pin <= gp;
    seq_cnt = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    por_done_pin <= 1'b1;
    repeat (12) @(posedge pclk);
  endtask : do_reset

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task scen_regs;
    logic [31:0] rd;
    logic err;
    rd_chk("dsc_rst", pmic_cfg_pkg::ADDR_DISCHARGE, 32'h00000000);
    rd_chk("uv_rst", pmic_cfg_pkg::ADDR_UV_SOURCE, 32'h00000002);
    rd_chk("en_rst", pmic_cfg_pkg::ADDR_ENABLES, 32'h00000000);
    wr(pmic_cfg_pkg::ADDR_DISCHARGE, 32'hFFFFFFFF);
    rd_chk("dsc_ff", pmic_cfg_pkg::ADDR_DISCHARGE, 32'h000000E7);
    check("hys_fet", {30'h0, boost_hysteresis_off, buck_fet_scaling}, 32'h3);
    wr(pmic_cfg_pkg::ADDR_UV_SOURCE, 32'hFFFFFFFF);
    rd_chk("uv_ff", pmic_cfg_pkg::ADDR_UV_SOURCE, 32'h00000003);
    check("ldo_uv", {31'h0, ldo_uv_use_converter_input}, 32'h1);
    wr(pmic_cfg_pkg::ADDR_UV_SOURCE, 32'h00000000);
    rd_chk("uv_00", pmic_cfg_pkg::ADDR_UV_SOURCE, 32'h00000002);
    check("ldo_uv0", {31'h0, ldo_uv_use_converter_input}, 32'h0);
    check("conv_uv", {31'h0, converter_uv_use_converter_input}, 32'h1);
    apb(1'b0, 8'hFC, 32'h0, rd, err);
    check("unmapped_err", {31'h0, err}, 32'h1);
    check("unmapped_data", rd, 32'h00000000);
  endtask : scen_regs

  task scen_straps(input logic [31:0] hs, input logic off, input logic loads);
    check("in_off", {31'h0, in_off_mode}, {31'h0, off});
    check("seq_start", seq_cnt, {31'h0, ~off});
    check("loads", {31'h0, passive_loads_enable}, {31'h0, loads});
    rd_chk("handshake", pmic_cfg_pkg::ADDR_HANDSHAKE, hs);
    wr(pmic_cfg_pkg::ADDR_HANDSHAKE, 32'h00000000);
    rd_chk("handshake_ro", pmic_cfg_pkg::ADDR_HANDSHAKE, hs);
  endtask : scen_straps

  task scen_policy;
    static logic [7:0] cfg [6] = '{8'h00, 8'h66, 8'h66, 8'h20, 8'h06, 8'h40};
    static logic [7:0] en [6] = '{8'h00, 8'h00, 8'h05, 8'h04, 8'h01, 8'h00};
    static logic [3:0] mask [6] = '{4'h0, 4'hF, 4'h0, 4'h4, 4'h3, 4'h8};
    for (int r = 0; r < 6; r++) begin
      wr(pmic_cfg_pkg::ADDR_DISCHARGE, {24'h0, cfg[r]});
      clear_cnt();
      wr(pmic_cfg_pkg::ADDR_ENABLES, {24'h0, en[r]});
      repeat (3) @(posedge pclk);
      for (int i = 0; i < 4; i++) check("dsc_cnt", cnt[i], {31'h0, mask[r][i]});
      check("en_fields", {28'h0, buck_enable_field, boost_enable_field}, {24'h0, en[r]});
    end
  endtask : scen_policy

  task scen_entry(input int k, input logic off, input logic loads);
    wr(pmic_cfg_pkg::ADDR_DISCHARGE, 32'h00000000);
    clear_cnt();
    req(k);
    for (int i = 0; i < 4; i++) check("entry_cnt", cnt[i], 32'h1);
    check("entry_off", {31'h0, in_off_mode}, {31'h0, off});
    check("entry_loads", {31'h0, passive_loads_enable}, {31'h0, loads});
  endtask : scen_entry

  // --------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    do_reset(1'b1, 1'b1);
    scen_straps(32'h000000C0, 1'b1, 1'b1);
    scen_regs();
    seq_cnt = 0;
    req(2);
    check("wake_seq", seq_cnt, 32'h1);
    check("wake_on", {30'h0, in_off_mode, passive_loads_enable}, 32'h0);
    scen_policy();
    scen_entry(1, 1'b0, 1'b0);
    scen_entry(0, 1'b1, 1'b1);
    do_reset(1'b0, 1'b0);
    scen_straps(32'h00000000, 1'b0, 1'b0);
    scen_entry(0, 1'b1, 1'b0);
    results();
  end

  // Run needs about 200 cycles; the margin covers slow handshakes
  initial begin
    #200000;
    failures++;
    results();
  end
endmodule : tb
`default_nettype wire
